// ===== bench/dppaf_pad_model.sv
// pad model: outside devices and pull-ups on one 8-bit port
`timescale 1ns/1ps
`default_nettype none
module dppaf_pad_model (
  input  wire logic [7:0] pinOut, // level the port drives
  input  wire logic [7:0] pinOe,  // port drives when high
  input  wire logic [7:0] extVal, // level an outside device drives
  input  wire logic [7:0] extEn,  // outside device drives when high
  output logic      [7:0] pinIn   // resolved pad level
);
  // ==========================================================
  // pad resolution
  // port drive wins over a clash, so an output pin is seen at its own pad
  // released pins rise on the pull-up, which makes the open-drain high level
  assign pinIn = (pinOe & pinOut) | (~pinOe & ~extEn) | (~pinOe & extEn & extVal);
endmodule // dppaf_pad_model
`default_nettype wire

// ===== bench/dppaf_port_tb_top.sv
// self-checking bench for the dual parallel port block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, o) begin num_checks++; if ((o) !== (e)) begin err_total++; $display("BAD %s %h %h", n, e, o); end end
module dppaf_port_tb_top;
  import dppaf_pkg::*;
  // ==========================================================
  // stimulus, all zero at time zero
  logic        mclk = 0, rst_n = 0, cfgWe = 0, serAOutEn = 0, serBOutEn = 0, slaveEnIn = 0, timerTick = 0;
  logic        serATx = 0, serBTx = 0, ioCycle = 0, ioRd = 0, ioWr = 0, irqAck0 = 0, irqAck1 = 0;
  logic [7:0]  dDirIn = 0, dOdIn = 0, dDataIn = 0, dTimedIn = 0, eDirIn = 0, eDataIn = 0, eTimedIn = 0;
  logic [7:0]  eStbEnIn = 0, irqEdgeIn = 0, extDv = 0, extDe = 0, extEv = 0, extEe = 0, v, w, d1, d2, r;
  logic [15:0] eStbKindIn = 0, ioAddr = 0;
  // outputs and pads
  logic        serARx, serBRx, irqReq0, irqReq1, slaveSelect_n;
  logic [7:0]  dPinIn, dPinOut, dPinOe, ePinIn, ePinOut, ePinOe, dRead, eRead;
  logic [55:0] obs;        // packed view of everything checked
  logic        stbOn;      // expected strobe activity
  int          seed = 32'hFE24, err_total = 0, num_checks = 0, cycles = 0;
  typedef struct {string nm; logic [55:0] m; logic [55:0] e;} dppaf_note_t;
  dppaf_note_t q[$];       // expected results, oldest first
  event        look;       // a result is noted at the edge, due for comparison once it settles
  always #5 mclk = ~mclk;
  dppaf_port dut_u (.mclk, .rst_n, .cfgWe, .dDirIn, .dOdIn, .dDataIn, .dTimedIn, .serAOutEn, .serBOutEn,
    .eDirIn, .eDataIn, .eTimedIn, .eStbEnIn, .eStbKindIn, .slaveEnIn, .irqEdgeIn, .timerTick, .serATx,
    .serBTx, .serARx, .serBRx, .ioCycle, .ioRd, .ioWr, .ioAddr, .irqAck0, .irqAck1, .irqReq0, .irqReq1,
    .slaveSelect_n, .dPinIn, .dPinOut, .dPinOe, .ePinIn, .ePinOut, .ePinOe, .dRead, .eRead);
  dppaf_pad_model padD_u (.pinOut(dPinOut), .pinOe(dPinOe), .extVal(extDv), .extEn(extDe), .pinIn(dPinIn));
  dppaf_pad_model padE_u (.pinOut(ePinOut), .pinOe(ePinOe), .extVal(extEv), .extEn(extEe), .pinIn(ePinIn));
  assign obs = {eRead, dPinOut, dPinOe, ePinOut, ePinOe, dRead, 3'h0, irqReq0, irqReq1, slaveSelect_n, serARx,
                serBRx};
  // ==========================================================
  // shared tasks
  task automatic cyc(int n);
    repeat (n) @(posedge mclk);
  endtask
  // one-cycle load of every setting; results settle one cycle later
  task automatic load();
    @(posedge mclk) cfgWe <= 1;
    @(posedge mclk) cfgWe <= 0;
  endtask
  // note an expectation at the edge; the watcher looks once this edge has landed
  task automatic note(string nm, logic [55:0] m, logic [55:0] e);
    q.push_back('{nm, m, e});
    -> look;
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // watcher: compares the oldest note with the outputs
  always @(look) begin
    dppaf_note_t n;
    n = q.pop_front();
    #1;
    `CHK(n.nm, n.e, obs & n.m)
  end
  // hang guard, far above the roughly ninety cycles of the run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    cyc(10);
    rst_n <= 1;
    cyc(1);
    note("rst", 48'h00FF_00FF_001C, 48'h4);
    v = $random(seed); w = $random(seed); d1 = $random(seed); d2 = $random(seed);
    dDirIn <= v; eDirIn <= w; dDataIn <= d1; eDataIn <= d2;
    load();
    note("dir", {v, 8'hFF, w, 8'hFF, 16'h0}, {d1 & v, v, d2 & w, w, 16'h0});
    dTimedIn <= 8'hFF; eTimedIn <= 8'hFF; dDataIn <= ~d1; eDataIn <= ~d2;
    load();
    note("held", {v, 8'h0, w, 24'h0}, {d1 & v, 8'h0, d2 & w, 24'h0});
    @(posedge mclk) timerTick <= 1;
    @(posedge mclk) timerTick <= 0;
    note("tick", {v, 8'h0, w, 24'h0}, {~d1 & v, 8'h0, ~d2 & w, 24'h0});
    dTimedIn <= 0; eTimedIn <= 0; dDirIn <= 8'hFF; dOdIn <= 8'hFF; dDataIn <= d1;
    load();
    note("od", 48'hFF << 32, {8'h0, ~d1, 32'h0});
    cyc(2);
    note("pad", 48'hFF00, {32'h0, d1, 8'h0});
    r = $random(seed);
    dOdIn <= 0; dDirIn <= 8'h5F; serAOutEn <= 1; serBOutEn <= 1; serATx <= r[0]; serBTx <= r[1];
    extDe <= 8'hA0; extDv <= {r[2], 1'b0, r[3], 5'h0};
    load();
    note("stx", 48'h50 << 40, 48'({r[0], 1'b0, r[1], 4'h0}) << 40);
    cyc(2);
    note("srx", 48'h3, {46'h0, r[2], r[3]});
    eDirIn <= 8'h04; eStbEnIn <= 8'h04;  // strobe 2 set as output
    for (int k = 0; k < 4; k++) begin
      eStbKindIn <= 16'(k) << 4;
      load();
      for (int o = 0; o < 3; o++) begin
        ioCycle <= 1; ioRd <= (o == 0); ioWr <= (o != 0); ioAddr <= {(o == 2) ? 3'd5 : 3'd2, 13'($random(seed))};
        @(posedge mclk);
        // kinds: 0 chip select, 1 write, 2 read, 3 read or write; o 0 reads, 1 writes, 2 misses the slice
        stbOn = o < 2 && (k == 0 || k == 3 || (k == 1 && o == 1) || (k == 2 && o == 0));
        note("stb", 48'h1 << 26, 48'(!stbOn) << 26);
        @(posedge mclk);
      end
      ioCycle <= 0;
    end
    eStbEnIn <= 0; eDirIn <= 0; slaveEnIn <= 1; extEe <= 8'h80; extEv <= 8'h00;
    load();
    cyc(3);
    note("ssel", 48'h4, 48'h0);
    eDirIn <= 8'h80; eDataIn <= 0; extEe <= 8'hFF; extEv <= 8'hFF;
    load();
    cyc(3);
    note("sslo", 48'h4, 48'h0);
    slaveEnIn <= 0; eDirIn <= 0; irqEdgeIn <= 8'hA5; extEv <= 8'hFD;
    load();
    cyc(3);
    extEv <= 8'hFC;
    cyc(3);
    note("i0", 48'h18, 48'h10);
    @(posedge mclk) irqAck0 <= 1;
    @(posedge mclk) irqAck0 <= 0;
    note("ack", 48'h18, 48'h0);
    extEv <= 8'hEC;
    cyc(3);
    note("i4", 48'h18, 48'h10);
    extEv <= 8'hEE;
    cyc(3);
    note("i1", {8'hFF, 48'h8}, {8'hEE, 48'h8});
    @(posedge mclk) irqAck1 <= 1;
    @(posedge mclk) irqAck1 <= 0;
    note("ack1", 48'h8, 48'h0);
    irqEdgeIn <= 8'hF5; // pins 1 and 5 now on both edges
    load();
    extEv <= 8'hCE;
    cyc(3);
    note("both", {8'hFF, 48'h8}, {8'hCE, 48'h8});
    cyc(1);
    tally_and_finish();
  end
endmodule // dppaf_port_tb_top
`default_nettype wire

// ===== src/dppaf_pkg.sv
// package of constants and types for the dual parallel port block
package dppaf_pkg;
  // ==========================================================
  // widths and reset values
  localparam int          DPPAF_WIDTH      = 8;
  localparam int          DPPAF_ADDR_W     = 16;
  localparam int          DPPAF_SLICE_LSB  = 13;   // upper three address bits pick the 8K slice
  localparam logic [7:0]  DPPAF_DIR_RST    = 8'h00; // all bits inputs after reset
  localparam logic [7:0]  DPPAF_DATA_RST   = 8'h00;
  localparam logic [7:0]  DPPAF_CFG_RST    = 8'h00;
  localparam logic [7:0]  DPPAF_SYNC_RST   = 8'hFF;    // pads idle high on their pull-ups
  localparam logic [15:0] DPPAF_KIND_RST   = 16'h0000; // every strobe a chip select
  localparam logic [3:0]  DPPAF_IRQ_RST    = 4'h0;     // no request pending
  // bit positions of alternate functions
  localparam int          DPPAF_SA_OUT_BIT = 6;
  localparam int          DPPAF_SB_OUT_BIT = 4;
  localparam int          DPPAF_SA_IN_BIT  = 7;
  localparam int          DPPAF_SB_IN_BIT  = 5;
  localparam int          DPPAF_SCS_BIT    = 7;
  localparam int          DPPAF_IRQ_PIN [4] = '{0, 4, 1, 5}; // latch order: irq0 pins, then irq1 pins
  // ==========================================================
  // strobe kinds and edge selections
  typedef enum logic [1:0] {
    DPPAF_STB_CS, DPPAF_STB_WR, DPPAF_STB_RD, DPPAF_STB_RW
  } dppaf_stb_t;
  typedef enum logic [1:0] {
    DPPAF_EDGE_OFF, DPPAF_EDGE_FALL, DPPAF_EDGE_RISE, DPPAF_EDGE_BOTH
  } dppaf_edge_t;
endpackage

// ===== src/dppaf_port.sv
// two 8-bit parallel ports with strobes, serial alternates and edge interrupts
//
// Behaviour
// - first port direction set per bit
// - first port push-pull or open-drain per bit
// - outputs held, loaded on timer event
// - bit6 sends serial A, bit4 serial B
// - bits 7,5 feed serial inputs A,B
// - second port direction set per bit
// - second port bits selectable as strobes
// - strobe asserts only in its 8K slice
// - strobe kind chip select, write, read, both
// - bit 7 is slave select when enabled
// - slave select taken from pin level
// - bits 0,4 irq0; bits 1,5 irq1
// - edge select fall, rise or both
// - per-pin edge detect then OR
// - separate request latch per pin
// - interrupt pins sampled at the pad
`timescale 1ns/1ps
`default_nettype none
module dppaf_port
  import dppaf_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // configuration written by software
  input  wire logic        cfgWe,          // load all settings this cycle
  input  wire logic [7:0]  dDirIn,         // first port direction, 1 = output
  input  wire logic [7:0]  dOdIn,          // first port open drain select
  input  wire logic [7:0]  dDataIn,        // first port output data
  input  wire logic [7:0]  dTimedIn,       // first port bit waits for timer
  input  wire logic        serAOutEn,      // bit6 carries serial A output
  input  wire logic        serBOutEn,      // bit4 carries serial B output
  input  wire logic [7:0]  eDirIn,         // second port direction
  input  wire logic [7:0]  eDataIn,        // second port output data
  input  wire logic [7:0]  eTimedIn,       // second port bit waits for timer
  input  wire logic [7:0]  eStbEnIn,       // bit acts as strobe
  input  wire logic [15:0] eStbKindIn,     // two bits per strobe kind
  input  wire logic        slaveEnIn,      // slave port enabled
  input  wire logic [7:0]  irqEdgeIn,      // two bits per pin: 0,4,1,5 order
  input  wire logic        timerTick,      // timer event pulse
  // serial and bus side, same clock
  input  wire logic        serATx,
  input  wire logic        serBTx,
  output logic             serARx,
  output logic             serBRx,
  input  wire logic        ioCycle,        // external io cycle in progress
  input  wire logic        ioRd,
  input  wire logic        ioWr,
  input  wire logic [15:0] ioAddr,
  input  wire logic        irqAck0,        // clear irq0 latches
  input  wire logic        irqAck1,
  output logic             irqReq0,
  output logic             irqReq1,
  output logic             slaveSelect_n,
  // pins
  input  wire logic [7:0]  dPinIn,
  output logic [7:0]       dPinOut,
  output logic [7:0]       dPinOe,
  input  wire logic [7:0]  ePinIn,
  output logic [7:0]       ePinOut,
  output logic [7:0]       ePinOe,
  output logic [7:0]       dRead,          // synchronised pin levels
  output logic [7:0]       eRead
);
  // ==========================================================
  // configuration storage
  logic [7:0]  dDir_r, dOd_r, dTimed_r, eDir_r, eTimed_r, eStbEn_r; // per-bit settings
  logic [15:0] eStbKind_r;                                           // strobe kinds
  logic [7:0]  irqEdge_r;                                            // edge selections
  logic        serAOut_r, serBOut_r, slaveEn_r;                      // alternate enables
  logic [7:0]  dPend_r, ePend_r;                                     // staged data
  logic [7:0]  dHold_r, eHold_r;                                     // output holding registers

  // settings load in one cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dDir_r <= DPPAF_DIR_RST; dOd_r <= DPPAF_CFG_RST; dTimed_r <= DPPAF_CFG_RST;
      eDir_r <= DPPAF_DIR_RST; eTimed_r <= DPPAF_CFG_RST; eStbEn_r <= DPPAF_CFG_RST;
      eStbKind_r <= DPPAF_KIND_RST; irqEdge_r <= DPPAF_CFG_RST;
      serAOut_r <= 1'b0; serBOut_r <= 1'b0; slaveEn_r <= 1'b0;
    end else if (cfgWe) begin
      dDir_r     <= dDirIn;
      dOd_r      <= dOdIn;
      dTimed_r   <= dTimedIn;
      eDir_r     <= eDirIn;
      eTimed_r   <= eTimedIn;
      eStbEn_r   <= eStbEnIn;
      eStbKind_r <= eStbKindIn;
      irqEdge_r  <= irqEdgeIn;
      serAOut_r  <= serAOutEn;
      serBOut_r  <= serBOutEn;
      slaveEn_r  <= slaveEnIn;
    end
  end

  // ==========================================================
  // holding registers: immediate bits follow a write, timed bits wait for the tick
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dPend_r <= DPPAF_DATA_RST; ePend_r <= DPPAF_DATA_RST;
      dHold_r <= DPPAF_DATA_RST; eHold_r <= DPPAF_DATA_RST;
    end else begin
      if (cfgWe) begin
        dPend_r <= dDataIn;
        ePend_r <= eDataIn;
      end
      for (int i = 0; i < DPPAF_WIDTH; i++) begin
        // a write and a tick together: immediate bits take new data, timed bits the old stage
        if (cfgWe && !dTimedIn[i]) dHold_r[i] <= dDataIn[i];
        else if (timerTick && dTimed_r[i]) dHold_r[i] <= dPend_r[i];
        if (cfgWe && !eTimedIn[i]) eHold_r[i] <= eDataIn[i];
        else if (timerTick && eTimed_r[i]) eHold_r[i] <= ePend_r[i];
      end
    end
  end

  // ==========================================================
  // pad synchronisers, two stages before any reader
  logic [7:0] dMeta_r, dSync_r, eMeta_r, eSync_r, ePrev_r;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // idle-high reset matches the pull-ups, so no false edge follows reset
      dMeta_r <= DPPAF_SYNC_RST; dSync_r <= DPPAF_SYNC_RST;
      eMeta_r <= DPPAF_SYNC_RST; eSync_r <= DPPAF_SYNC_RST; ePrev_r <= DPPAF_SYNC_RST;
    end else begin
      dMeta_r <= dPinIn; dSync_r <= dMeta_r;
      eMeta_r <= ePinIn; eSync_r <= eMeta_r;
      ePrev_r <= eSync_r;
    end
  end
  assign dRead = dSync_r;
  assign eRead = eSync_r;
  assign serARx = dSync_r[DPPAF_SA_IN_BIT];
  assign serBRx = dSync_r[DPPAF_SB_IN_BIT];
  // pad level drives slave select, so an output driven low holds it asserted
  assign slaveSelect_n = slaveEn_r ? eSync_r[DPPAF_SCS_BIT] : 1'b1;

  // ==========================================================
  // first port drive and second port strobes
  logic [7:0] dVal;
  always_comb begin
    dVal = dHold_r;
    if (serAOut_r) dVal[DPPAF_SA_OUT_BIT] = serATx;
    if (serBOut_r) dVal[DPPAF_SB_OUT_BIT] = serBTx;
  end
  generate
    for (genvar g = 0; g < DPPAF_WIDTH; g++) begin : gDrive
      // open drain only ever drives low
      assign dPinOut[g] = dOd_r[g] ? 1'b0 : dVal[g];
      assign dPinOe[g]  = dDir_r[g] & (~dOd_r[g] | ~dVal[g]);
      // strobe: slice match by top address bits, qualified by kind, active low
      logic hit;
      assign hit = ioCycle && (ioAddr[DPPAF_ADDR_W-1:DPPAF_SLICE_LSB] == 3'(g));
      logic act;
      always_comb begin
        case (dppaf_stb_t'(eStbKind_r[2*g +: 2]))
          DPPAF_STB_CS: act = hit;
          DPPAF_STB_WR: act = hit && ioWr;
          DPPAF_STB_RD: act = hit && ioRd;
          DPPAF_STB_RW: act = hit && (ioRd || ioWr);
          default:      act = 1'b0;
        endcase
      end
      // strobe only reaches the pin when the bit is an output
      assign ePinOut[g] = eStbEn_r[g] ? ~act : eHold_r[g];
      assign ePinOe[g]  = eDir_r[g];
    end
  endgenerate

  // ==========================================================
  // interrupt latches, one per pin: index 0..3 = pins 0,4,1,5
  logic [3:0] irqLatch_r;                       // request latch per pin
  logic [3:0] hitEdge;                          // selected transition seen this cycle
  generate
    for (genvar k = 0; k < 4; k++) begin : gIrq
      logic rise, fall, sel;
      assign rise = eSync_r[DPPAF_IRQ_PIN[k]] & ~ePrev_r[DPPAF_IRQ_PIN[k]];
      assign fall = ~eSync_r[DPPAF_IRQ_PIN[k]] & ePrev_r[DPPAF_IRQ_PIN[k]];
      // local select keeps each bit of hitEdge under a single process
      always_comb begin
        case (dppaf_edge_t'(irqEdge_r[2*k +: 2]))
          DPPAF_EDGE_FALL: sel = fall;
          DPPAF_EDGE_RISE: sel = rise;
          DPPAF_EDGE_BOTH: sel = rise | fall;
          default:         sel = 1'b0;
        endcase
      end
      assign hitEdge[k] = sel;
    end
  endgenerate
  // set wins over acknowledge
  always_ff @(posedge mclk) begin
    if (!rst_n) irqLatch_r <= DPPAF_IRQ_RST;
    else begin
      for (int k = 0; k < 4; k++) begin
        if (hitEdge[k]) irqLatch_r[k] <= 1'b1;
        else if ((k < 2) ? irqAck0 : irqAck1) irqLatch_r[k] <= 1'b0;
      end
    end
  end
  assign irqReq0 = irqLatch_r[0] | irqLatch_r[1];
  assign irqReq1 = irqLatch_r[2] | irqLatch_r[3];

  // ==========================================================
  // checks
  AST_SLICE: assert property (@(posedge mclk) disable iff (!rst_n)
    (eStbEn_r[2] && !ePinOut[2]) |-> (ioCycle && ioAddr[DPPAF_ADDR_W-1:DPPAF_SLICE_LSB] == 3'h2))
    else $error("strobe 2 outside its slice");
  AST_OD: assert property (@(posedge mclk) disable iff (!rst_n)
    (dOd_r[0] && dPinOe[0]) |-> !dPinOut[0])
    else $error("open drain drove high");
  AST_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    !dDir_r[3] |-> !dPinOe[3])
    else $error("input bit driven");
  AST_TIMED: assert property (@(posedge mclk) disable iff (!rst_n)
    (dTimed_r[1] && !timerTick && !cfgWe) |=> $stable(dHold_r[1]))
    else $error("timed bit moved without tick");
  AST_SER: assert property (@(posedge mclk) disable iff (!rst_n)
    (serAOut_r && dDir_r[6] && !dOd_r[6]) |-> dPinOut[6] == serATx)
    else $error("serial A out not on bit 6");
  AST_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    hitEdge[0] |=> irqLatch_r[0] ##0 irqReq0)
    else $error("edge not latched");
  AST_FALL: assert property (@(posedge mclk) disable iff (!rst_n)
    (irqEdge_r[1:0] == 2'h1 && $fell(eSync_r[0]) && !cfgWe) |-> hitEdge[0])
    else $error("falling edge missed");
  AST_SCS: assert property (@(posedge mclk) disable iff (!rst_n)
    (slaveEn_r && $past(rst_n, 2) && !$past(ePinIn[DPPAF_SCS_BIT], 2)) |-> !slaveSelect_n)
    else $error("slave select not from pin");
endmodule // dppaf_port
`default_nettype wire
